// file: dma_cfg.svh
/*
  Constants of the four-channel transfer engine: widths, sizes, memory windows.
  Assumes inclusion by bare name from the package and the engine.
*/
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH

`define DMA_NUM_CH      4
`define DMA_ADDR_W      24
`define DMA_BLK_W       16
`define DMA_REP_W       8
`define DMA_BLK_FULL    17'h10000
`define DMA_REP_FULL    9'h100
`define DMA_EEP_BASE    24'h001000
`define DMA_EEP_LAST    24'h0017FF

`endif

// file: dma_pkg.sv
/*
  Types shared by the transfer engine and its surroundings.
  Assumes dma_cfg.svh is on the include path.
*/
`include "dma_cfg.svh"

package dma_pkg;

  typedef logic [`DMA_ADDR_W-1:0] addr_t;

  typedef enum logic [1:0] {AM_FIXED, AM_INC, AM_DEC}             addr_mode_e;
  typedef enum logic [1:0] {RL_NONE, RL_BURST, RL_BLOCK, RL_TXN}  reload_e;
  typedef enum logic [1:0] {TS_SOFT, TS_PERIPH, TS_EVENT}         trig_sel_e;
  typedef enum logic [1:0] {BL_1, BL_2, BL_4, BL_8}               burst_len_e;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE}           eng_state_e;

  // Per-channel setup, held steady by the user while a channel runs
  typedef struct packed {
    logic                  enable;
    trig_sel_e             trig_sel;
    burst_len_e            burst_len;
    logic [`DMA_BLK_W-1:0] blk_size;    // Zero means 64K bytes
    logic [`DMA_REP_W-1:0] repeat_cnt;  // Zero means 256 blocks
    addr_t                 src_addr;
    addr_t                 dst_addr;
    addr_mode_e            src_mode;
    addr_mode_e            dst_mode;
    reload_e               src_reload;
    reload_e               dst_reload;
    logic                  link;
    logic                  crc_en;
    logic                  irq_done_en;
    logic                  irq_err_en;
  } ch_cfg_s;

  typedef struct packed {
    logic  req;
    addr_t addr;
  } rd_bus_s;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } rd_rsp_s;

  typedef struct packed {
    logic       req;
    addr_t      addr;
    logic [7:0] data;
  } wr_bus_s;

  typedef struct packed {
    logic ack;
    logic err;
  } wr_rsp_s;

endpackage

// file: dma_ctrl.sv
/*
  Four-channel byte transfer engine with separate read and write bus masters,
  block/repeat counting, address stepping and reload, chaining and CRC feed.
  Assumes single-clock memories that hold a request until they answer it.
*/
`timescale 1ns/100ps

`include "dma_cfg.svh"

// Contract
// - Four channels run transfers independently, interleaved burst by burst.
// - Each burst moves one, two, four or eight bytes without a break, fewer when the block ends first.
// - Bursts form a block sized from one byte to 64K bytes.
// - Repeat counter re-runs blocks, up to 16M bytes per transaction.
// - Source and destination each stay fixed, count up or count down.
// - Addresses optionally restore after each burst, block or transaction end.
// - Transfers start by software, peripheral or event trigger.
// - Every channel holds its own addresses, trigger, sizes and interrupt setup.
// - Optional interrupt on transaction done or on channel error.
// - Linked channel pair hands over on completion, back and forth.
// - Moved bytes optionally feed the CRC generator.
// - Reads from memory-mapped EEPROM starting at 0x1000 are supported.
// - Read master and write master may use separate memories, but never request in the same cycle.
module dma_ctrl #(
  parameter int NUM_CH = `DMA_NUM_CH
) (
  input  wire logic                        mclk_in,
  input  wire logic                        reset_in,
  input  wire dma_pkg::ch_cfg_s [NUM_CH-1:0] cfg_in,
  input  wire logic [NUM_CH-1:0]           sw_trig_in,
  input  wire logic [NUM_CH-1:0]           per_trig_in,
  input  wire logic [NUM_CH-1:0]           evt_trig_in,
  input  wire logic [NUM_CH-1:0]           clr_done_in,
  input  wire logic [NUM_CH-1:0]           clr_err_in,
  output dma_pkg::rd_bus_s                 rd_bus_out,
  input  wire dma_pkg::rd_rsp_s            rd_rsp_in,
  output dma_pkg::wr_bus_s                 wr_bus_out,
  input  wire dma_pkg::wr_rsp_s            wr_rsp_in,
  output logic                             rd_eeprom_out,
  output logic [NUM_CH-1:0]                busy_out,
  output logic [NUM_CH-1:0]                done_out,
  output logic [NUM_CH-1:0]                err_out,
  output logic [NUM_CH-1:0]                irq_out,
  output logic                             crc_valid_out,
  output logic [7:0]                       crc_byte_out
);
  import dma_pkg::*;

  // Channel index width, one bit at least
  localparam int CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

  // Chaining pairs neighbours, so the channel count must be even
  if (NUM_CH < 2 || NUM_CH > 8 || (NUM_CH % 2) != 0) begin : g_bad_ch
    $error("dma_ctrl: NUM_CH must be even and from 2 to 8");
  end

  // Address step after each byte
  function automatic addr_t step_addr(input addr_t a, input addr_mode_e m);
    case (m)
      AM_INC:  step_addr = a + addr_t'(1);
      AM_DEC:  step_addr = a - addr_t'(1);
      default: step_addr = a;
    endcase
  endfunction

  // Engine state, served channel and per-channel counters
  eng_state_e             state_r,   state_nxt;
  logic [CH_W-1:0]        cur_r,     cur_nxt;
  logic [7:0]             data_r,    data_nxt;
  logic                   crc_v_r,   crc_v_nxt;
  logic [7:0]             crc_b_r,   crc_b_nxt;
  addr_t                  src_r      [NUM_CH];
  addr_t                  src_nxt    [NUM_CH];
  addr_t                  dst_r      [NUM_CH];
  addr_t                  dst_nxt    [NUM_CH];
  logic [16:0]            blk_r      [NUM_CH];
  logic [16:0]            blk_nxt    [NUM_CH];
  logic [8:0]             rep_r      [NUM_CH];
  logic [8:0]             rep_nxt    [NUM_CH];
  logic [3:0]             brst_r     [NUM_CH];
  logic [3:0]             brst_nxt   [NUM_CH];
  logic [NUM_CH-1:0]      act_r,     act_nxt;
  logic [NUM_CH-1:0]      done_r,    done_nxt;
  logic [NUM_CH-1:0]      err_r,     err_nxt;
  logic [NUM_CH-1:0]      trig_hit;
  logic [NUM_CH-1:0]      start_v;

  // Trigger selection per channel; errored or running channels ignore it
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      case (cfg_in[i].trig_sel)
        TS_SOFT:   trig_hit[i] = sw_trig_in[i];
        TS_PERIPH: trig_hit[i] = per_trig_in[i];
        TS_EVENT:  trig_hit[i] = evt_trig_in[i];
        default:   trig_hit[i] = 1'b0;
      endcase
      trig_hit[i] = trig_hit[i] & cfg_in[i].enable & ~act_r[i] & ~err_r[i];
    end
  end

  // Engine and per-channel bookkeeping
  always_comb begin
    // Working values for the served channel
    logic             found;
    logic [CH_W-1:0]  idx;
    logic [CH_W-1:0]  c;
    logic             brst_last;
    logic             blk_last;
    logic             txn_end;
    logic             rl_src;
    logic             rl_dst;
    found     = 1'b0;
    idx       = cur_r;
    c         = cur_r;
    brst_last = 1'b0;
    blk_last  = 1'b0;
    txn_end   = 1'b0;
    rl_src    = 1'b0;
    rl_dst    = 1'b0;
    // Hold registers, drop the CRC strobe and apply flag clears unless a branch below changes them
    state_nxt = state_r;
    cur_nxt   = cur_r;
    data_nxt  = data_r;
    crc_v_nxt = 1'b0;
    crc_b_nxt = crc_b_r;
    src_nxt   = src_r;
    dst_nxt   = dst_r;
    blk_nxt   = blk_r;
    rep_nxt   = rep_r;
    brst_nxt  = brst_r;
    act_nxt   = act_r;
    done_nxt  = done_r & ~clr_done_in;
    err_nxt   = err_r & ~clr_err_in;
    start_v   = trig_hit;
    case (state_r)
      ST_IDLE: begin
        // Round robin from the channel after the last served one
        for (int k = 1; k <= NUM_CH; k++) begin
          idx = CH_W'((int'(cur_r) + k) % NUM_CH);
          if (!found && act_r[idx]) begin
            found   = 1'b1;
            cur_nxt = idx;
          end
        end
        // Serve the chosen channel next cycle
        if (found) begin
          state_nxt = ST_READ;
        end
      end
      ST_READ: begin
        // Waits as long as the memory needs per byte
        if (rd_rsp_in.valid) begin
          // Read fault stops the channel without done
          if (rd_rsp_in.err) begin
            act_nxt[c] = 1'b0;
            err_nxt[c] = 1'b1;
            state_nxt  = ST_IDLE;
          end else begin
            data_nxt  = rd_rsp_in.data;
            state_nxt = ST_WRITE;
          end
        end
      end
      ST_WRITE: begin
        if (wr_rsp_in.ack) begin
          // Write fault stops the channel without done
          if (wr_rsp_in.err) begin
            act_nxt[c] = 1'b0;
            err_nxt[c] = 1'b1;
            state_nxt  = ST_IDLE;
          end else begin
            // Byte written: count down and step addresses
            blk_last  = (blk_r[c] == 17'h00001);
            brst_last = (brst_r[c] == 4'h1) || blk_last;
            txn_end   = blk_last && (rep_r[c] == 9'h001);
            src_nxt[c]  = step_addr(src_r[c], cfg_in[c].src_mode);
            dst_nxt[c]  = step_addr(dst_r[c], cfg_in[c].dst_mode);
            blk_nxt[c]  = blk_r[c] - 17'h00001;
            brst_nxt[c] = brst_r[c] - 4'h1;
            // Feed the written byte to the checksum unit
            if (cfg_in[c].crc_en) begin
              crc_v_nxt = 1'b1;
              crc_b_nxt = data_r;
            end
            // Burst ends hand the bus to the next channel
            state_nxt = brst_last ? ST_IDLE : ST_READ;
            // Burst count restarts from the setup
            if (brst_last) begin
              brst_nxt[c] = 4'(1 << cfg_in[c].burst_len);
            end
            // Block end restarts the block count, one repeat used
            if (blk_last) begin
              blk_nxt[c] = (cfg_in[c].blk_size == '0) ? `DMA_BLK_FULL
                                                      : 17'(cfg_in[c].blk_size);
              rep_nxt[c] = rep_r[c] - 9'h001;
            end
            // Address reload at burst, block or transaction end
            rl_src = (cfg_in[c].src_reload == RL_BURST && brst_last) ||
                     (cfg_in[c].src_reload == RL_BLOCK && blk_last) ||
                     (cfg_in[c].src_reload == RL_TXN && txn_end);
            rl_dst = (cfg_in[c].dst_reload == RL_BURST && brst_last) ||
                     (cfg_in[c].dst_reload == RL_BLOCK && blk_last) ||
                     (cfg_in[c].dst_reload == RL_TXN && txn_end);
            if (rl_src) begin
              src_nxt[c] = cfg_in[c].src_addr;
            end
            if (rl_dst) begin
              dst_nxt[c] = cfg_in[c].dst_addr;
            end
            // Completion; a linked, idle and clean partner takes over
            if (txn_end) begin
              act_nxt[c]  = 1'b0;
              done_nxt[c] = 1'b1;
              if (cfg_in[c].link && !err_r[c ^ CH_W'(1)] &&
                  !act_r[c ^ CH_W'(1)]) begin
                start_v[c ^ CH_W'(1)] = 1'b1;
              end
            end
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Transaction start loads the channel's own setup
    for (int i = 0; i < NUM_CH; i++) begin
      if (start_v[i]) begin
        act_nxt[i]  = 1'b1;
        src_nxt[i]  = cfg_in[i].src_addr;
        dst_nxt[i]  = cfg_in[i].dst_addr;
        brst_nxt[i] = 4'(1 << cfg_in[i].burst_len);
        blk_nxt[i]  = (cfg_in[i].blk_size == '0) ? `DMA_BLK_FULL
                                                 : 17'(cfg_in[i].blk_size);
        rep_nxt[i]  = (cfg_in[i].repeat_cnt == '0) ? `DMA_REP_FULL
                                                   : 9'(cfg_in[i].repeat_cnt);
      end
    end
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_r <= ST_IDLE;
      cur_r   <= '0;
      data_r  <= 8'h00;
      crc_v_r <= 1'b0;
      crc_b_r <= 8'h00;
      act_r   <= '0;
      done_r  <= '0;
      err_r   <= '0;
      // Per-channel counters and addresses
      for (int i = 0; i < NUM_CH; i++) begin
        src_r[i]  <= '0;
        dst_r[i]  <= '0;
        blk_r[i]  <= 17'h00000;
        rep_r[i]  <= 9'h000;
        brst_r[i] <= 4'h0;
      end
    end else begin
      // Take the next values
      state_r <= state_nxt;
      cur_r   <= cur_nxt;
      data_r  <= data_nxt;
      crc_v_r <= crc_v_nxt;
      crc_b_r <= crc_b_nxt;
      act_r   <= act_nxt;
      done_r  <= done_nxt;
      err_r   <= err_nxt;
      src_r   <= src_nxt;
      dst_r   <= dst_nxt;
      blk_r   <= blk_nxt;
      rep_r   <= rep_nxt;
      brst_r  <= brst_nxt;
    end
  end

  // Separate read and write masters
  assign rd_bus_out.req  = (state_r == ST_READ);
  assign rd_bus_out.addr = src_r[cur_r];
  assign wr_bus_out.req  = (state_r == ST_WRITE);
  assign wr_bus_out.addr = dst_r[cur_r];
  assign wr_bus_out.data = data_r;
  // Flags a read that targets the mapped EEPROM window
  assign rd_eeprom_out = (state_r == ST_READ) &&
                         (src_r[cur_r] >= `DMA_EEP_BASE) &&
                         (src_r[cur_r] <= `DMA_EEP_LAST);

  // Status and interrupt lines
  assign busy_out      = act_r;
  assign done_out      = done_r;
  assign err_out       = err_r;
  // Interrupt level from sticky flags and enables
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      irq_out[i] = (done_r[i] & cfg_in[i].irq_done_en) |
                   (err_r[i] & cfg_in[i].irq_err_en);
    end
  end
  assign crc_valid_out = crc_v_r;
  assign crc_byte_out  = crc_b_r;

endmodule

// file: dma_ctrl_props.sv
/* Checker on the engine ports: bus handshakes, flags, triggers.
   Assumes binding to dma_ctrl; one clock, synchronous reset. */
`timescale 1ns/100ps
module dma_ctrl_props
  import dma_pkg::*;
#(parameter int NUM_CH = 4) (
  input wire logic                 mclk_in,
  input wire logic                 reset_in,
  input wire ch_cfg_s [NUM_CH-1:0] cfg_in,
  input wire logic [NUM_CH-1:0]    sw_trig_in,
  input wire logic [NUM_CH-1:0]    clr_done_in,
  input wire rd_bus_s              rd_bus_out,
  input wire rd_rsp_s              rd_rsp_in,
  input wire wr_bus_s              wr_bus_out,
  input wire wr_rsp_s              wr_rsp_in,
  input wire logic                 rd_eeprom_out,
  input wire logic [NUM_CH-1:0]    busy_out,
  input wire logic [NUM_CH-1:0]    done_out,
  input wire logic [NUM_CH-1:0]    err_out,
  input wire logic [NUM_CH-1:0]    irq_out
);
  logic [NUM_CH-1:0] irq_exp;
  // Interrupt lines expected from flags and enables
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      irq_exp[i] = (done_out[i] & cfg_in[i].irq_done_en) | (err_out[i] & cfg_in[i].irq_err_en);
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Port relations
  property p_eep; rd_eeprom_out == (rd_bus_out.req && rd_bus_out.addr[23:11] == 13'h0002); endproperty
  a_eep: assert property (p_eep) else $error("eeprom flag wrong");
  property p_irq; irq_out == irq_exp; endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_rdh; rd_bus_out.req && !rd_rsp_in.valid |=> rd_bus_out.req && $stable(rd_bus_out); endproperty
  a_rdh: assert property (p_rdh) else $error("read dropped");
  property p_wrh; wr_bus_out.req && !wr_rsp_in.ack |=> wr_bus_out.req && $stable(wr_bus_out); endproperty
  a_wrh: assert property (p_wrh) else $error("write dropped");
  property p_rdwr;
    rd_bus_out.req && rd_rsp_in.valid && !rd_rsp_in.err |=> wr_bus_out.req && !rd_bus_out.req;
  endproperty
  a_rdwr: assert property (p_rdwr) else $error("no write after read");
  property p_done; done_out[0] && !clr_done_in[0] |=> done_out[0]; endproperty
  a_done: assert property (p_done) else $error("done lost");
  property p_gate; (busy_out & ~$past(busy_out) & $past(err_out)) == '0; endproperty
  a_gate: assert property (p_gate) else $error("errored channel started");
  property p_trig;
    cfg_in[0].enable && cfg_in[0].trig_sel == TS_SOFT && sw_trig_in[0] && !busy_out[0]
      && !err_out[0] |=> busy_out[0];
  endproperty
  a_trig: assert property (p_trig) else $error("trigger not taken");
endmodule
bind dma_ctrl dma_ctrl_props #(.NUM_CH(NUM_CH)) u_dma_ctrl_props (.mclk_in, .reset_in, .cfg_in,
  .sw_trig_in, .clr_done_in, .rd_bus_out, .rd_rsp_in, .wr_bus_out, .wr_rsp_in, .rd_eeprom_out,
  .busy_out, .done_out, .err_out, .irq_out);

// file: dma_mem_model.sv
/* Memory model on both engine buses: SRAM, EEPROM window, fault area.
   Assumes requests held until answered. */
`timescale 1ns/100ps
module dma_mem_model
  import dma_pkg::*;
(
  input  wire logic    mclk_in,
  input  wire logic    reset_in,
  input  wire logic    slow_in,
  input  wire rd_bus_s rd_bus_in,
  input  wire wr_bus_s wr_bus_in,
  output rd_rsp_s      rd_rsp_out,
  output wr_rsp_s      wr_rsp_out
);
  logic [7:0] mem [0:16383];
  logic       ph_r;
  logic       eep;
  initial for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h5A;
  assign eep = rd_bus_in.addr[23:11] == 13'h0002;
  // Phase toggle paces EEPROM and slow answers
  always_ff @(posedge mclk_in) begin
    ph_r <= reset_in ? 1'b0 : ~ph_r;
  end
  // SRAM reads answer at once, EEPROM reads and slow writes every second cycle
  always_comb begin
    rd_rsp_out.valid = rd_bus_in.req && (!eep || ph_r);
    rd_rsp_out.err = rd_bus_in.addr[23:14] != 10'h000; // Fault area
    rd_rsp_out.data = mem[rd_bus_in.addr[13:0]] ^ {8{!rd_rsp_out.valid}};
    wr_rsp_out.ack = wr_bus_in.req && (!slow_in || ph_r);
    wr_rsp_out.err = 1'b0;
  end
  // Store accepted writes
  always @(posedge mclk_in) begin
    if (wr_rsp_out.ack) mem[wr_bus_in.addr[13:0]] <= wr_bus_in.data;
  end
endmodule

// file: four_channel_dma_controller_test.sv
/* Self-checking bench for the four-channel engine.
   Assumes dma_ctrl, dma_mem_model and the bound checker. */
`timescale 1ns/100ps
module four_channel_dma_controller_test;
  import dma_pkg::*;
  logic          mclk_in = 1'b0, reset_in = 1'b1, slow = 1'b0, seen, eep, crcv;
  ch_cfg_s [3:0] cfg = '0;
  logic [3:0]    sw = '0, per = '0, evt = '0, cd = '0, ce = '0, busy, done, err, irq;
  rd_bus_s       rb;
  rd_rsp_s       rr;
  wr_bus_s       wb;
  wr_rsp_s       wa;
  logic [7:0]    crcb, crcq[$];
  int            fail_count = 0, checks_done = 0;
  dma_ctrl u_dma_ctrl (.mclk_in, .reset_in, .cfg_in(cfg), .sw_trig_in(sw), .per_trig_in(per),
    .evt_trig_in(evt), .clr_done_in(cd), .clr_err_in(ce), .rd_bus_out(rb), .rd_rsp_in(rr),
    .wr_bus_out(wb), .wr_rsp_in(wa), .rd_eeprom_out(eep), .busy_out(busy), .done_out(done),
    .err_out(err), .irq_out(irq), .crc_valid_out(crcv), .crc_byte_out(crcb));
  dma_mem_model u_dma_mem_model (.mclk_in, .reset_in, .slow_in(slow), .rd_bus_in(rb),
    .wr_bus_in(wb), .rd_rsp_out(rr), .wr_rsp_out(wa));
  initial forever #25 mclk_in = ~mclk_in;
  // Collect bytes fed to the checksum unit, sampled mid-cycle
  always @(negedge mclk_in) if (crcv === 1'b1) crcq.push_back(crcb);
  function automatic logic [7:0] fill(input logic [23:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] mem_at(input logic [23:0] a);
    return u_dma_mem_model.mem[a[13:0]];
  endfunction
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
    checks_done++;
    if (e !== s) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic setc(input int c, input addr_t s, input addr_t d, input addr_mode_e sm,
                      input addr_mode_e dm, input burst_len_e bl, input int blk, input trig_sel_e t);
    cfg[c] = '0;
    cfg[c].enable = 1'b1;
    cfg[c].trig_sel = t;
    cfg[c].burst_len = bl;
    cfg[c].blk_size = 16'(blk);
    cfg[c].repeat_cnt = 8'h01;
    cfg[c].src_addr = s;
    cfg[c].dst_addr = d;
    cfg[c].src_mode = sm;
    cfg[c].dst_mode = dm;
    cfg[c].crc_en = 1'b1;
    cfg[c].irq_done_en = 1'b1;
    cfg[c].irq_err_en = 1'b1;
    crcq = {};
  endtask
  // Pulse one trigger source, then wait for all channels idle
  task automatic go(input int c, input int k);
    @(negedge mclk_in);
    sw[c] = (k == 0);
    per[c] = (k == 1);
    evt[c] = (k == 2);
    @(negedge mclk_in);
    seen = busy[c];
    {sw, per, evt} = '0;
    for (int i = 0; i < 3000 && busy !== 4'h0; i++) @(negedge mclk_in);
    chk("idle", 4'h0, busy);
    @(negedge mclk_in);
  endtask
  task automatic clr(input int c);
    @(negedge mclk_in);
    {cd[c], ce[c]} = 2'h3;
    @(negedge mclk_in);
    {cd, ce} = '0;
  endtask
  // Two blocks of eight in four-byte bursts, source rewound per block
  task automatic s_inc;
    setc(0, 24'h002000, 24'h002100, AM_INC, AM_INC, BL_4, 8, TS_SOFT);
    cfg[0].repeat_cnt = 8'h02;
    cfg[0].src_reload = RL_BLOCK;
    go(0, 0);
    chk("start", 1, seen);
    for (int i = 0; i < 16; i++) chk("inc", fill(24'h2000 + i % 8), mem_at(24'h2100 + i));
    chk("beyond", fill(24'h2110), mem_at(24'h2110));
    chk("crc_cnt", 24'h10, crcq.size());
    chk("done", 1, done[0]);
    chk("irq", 1, irq[0]);
    clr(0);
    chk("irq_clr", 0, irq[0]);
  endtask
  // EEPROM source counting down into a fixed destination
  task automatic s_eep;
    setc(1, 24'h001007, 24'h002200, AM_DEC, AM_FIXED, BL_8, 8, TS_PERIPH);
    go(1, 1);
    chk("start", 1, seen);
    for (int i = 0; i < 8; i++) chk("crc_byte", fill(24'h1007 - i), crcq[i]);
    chk("fixed", fill(24'h1000), mem_at(24'h2200));
    chk("done", 3'h2, done[2:0]);
  endtask
  // Read fault, then a retrigger that is ignored
  task automatic s_err;
    setc(2, 24'h008000, 24'h002300, AM_INC, AM_INC, BL_2, 4, TS_EVENT);
    go(2, 2);
    chk("start", 1, seen);
    chk("err", 1, err[2]);
    chk("no_done", 0, done[2]);
    chk("irq_err", 1, irq[2]);
    go(2, 2);
    chk("blocked", 0, seen);
    clr(2);
    chk("err_clr", 0, err[2]);
  endtask
  // Channel three hands over to two; slow write answers
  task automatic s_link;
    slow = 1'b1;
    setc(2, 24'h002000, 24'h002500, AM_INC, AM_INC, BL_2, 4, TS_SOFT);
    setc(3, 24'h002000, 24'h002400, AM_INC, AM_INC, BL_1, 3, TS_SOFT);
    cfg[3].link = 1'b1;
    cfg[2].dst_reload = RL_TXN;
    cfg[3].src_reload = RL_BURST;
    go(3, 0);
    for (int i = 0; i < 3000 && done[2] !== 1'b1; i++) @(negedge mclk_in);
    chk("link", 4'hE, done);
    chk("rewind", fill(24'h2000), mem_at(24'h2402));
    chk("pair", fill(24'h2003), mem_at(24'h2503));
  endtask
  // Two channels triggered together, second one writing downwards
  task automatic s_par;
    setc(0, 24'h002000, 24'h002600, AM_INC, AM_INC, BL_2, 4, TS_SOFT);
    setc(1, 24'h002004, 24'h002700, AM_INC, AM_DEC, BL_1, 4, TS_SOFT);
    @(negedge mclk_in);
    sw = 4'h3;
    @(negedge mclk_in);
    sw = 4'h0;
    chk("both", 4'h3, busy & 4'h3);
    for (int i = 0; i < 3000 && busy !== 4'h0; i++) @(negedge mclk_in);
    @(negedge mclk_in);
    for (int i = 0; i < 4; i++) chk("par0", fill(24'h2000 + i), mem_at(24'h2600 + i));
    for (int i = 0; i < 4; i++) chk("par1", fill(24'h2004 + i), mem_at(24'h2700 - i));
    chk("par_crc", 24'h8, crcq.size());
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog far beyond the expected run length
  initial begin
    repeat (40000) @(posedge mclk_in);
    fail_count++;
    print_verdict;
  end
  initial begin
    repeat (12) @(negedge mclk_in);
    reset_in = 1'b0;
    s_inc;
    s_eep;
    s_err;
    s_link;
    s_par;
    print_verdict;
  end
endmodule
